// ### logic/rrf_radio_core.sv
// radio core data path: receive fifo, overflow handling, output pin, transmit byte fetch
// all strobes and config come from processor logic on the same 200 MHz clock
`timescale 1ns/10ps
`include "rrf_defs.svh"

// How it works
// - received bytes go through a one-byte prefetch stage into a 64-byte fifo, status and crc held aside.
// - a byte arriving while fifo and prefetch are both full moves the radio into the overflow state.
// - with pin select 0x06 the output pin drops once the receive fifo overflows.
// - recovery is the idle strobe then the flush strobe, which empties the fifo only out of receive.
// - in legacy mode some status/crc settings leave the radio stuck in receive, deaf, pin still high.
// - the byte fetch signal rises at each byte start and falls after half the byte has been sent.
// - in legacy mode an abort in the first half of a byte leaves fetch high and the next first byte repeats.
// - with packet handling on, transmit ends by itself after the last bit of the last byte.
module rrf_radio_core #(
    parameter int BIT_CYCLES = `RRF_BIT_CYCLES
) (
    input  wire logic                      clk,
    input  wire logic                      arst_n,
    input  wire logic                      idle_strobe,
    input  wire logic                      rx_strobe,
    input  wire logic                      tx_strobe,
    input  wire logic                      rx_flush_strobe,
    input  wire logic [`RRF_PIN_CFG_W-1:0] output_pin_select_cfg,
    input  wire logic                      status_append_enable,
    input  wire logic                      crc_enable,
    input  wire logic                      packet_handling_enable,
    input  wire logic                      legacy_defect_enable,
    input  wire logic                      rx_byte_valid,
    input  wire logic [7:0]                rx_byte,
    input  wire logic                      rx_pkt_start,
    input  wire logic                      rx_pkt_end,
    input  wire logic [7:0]                rx_rssi,
    input  wire logic [7:0]                rx_lqi,
    input  wire logic                      rx_crc_ok,
    input  wire logic                      rx_rd_en,
    output logic [7:0]                     rx_rd_data,
    output logic                           rx_rd_valid,
    output logic [`RRF_FIFO_AW:0]          rx_fifo_count,
    input  wire logic [7:0]                tx_data,
    input  wire logic                      tx_data_avail,
    input  wire logic                      tx_last,
    output logic                           tx_pop,
    output logic                           tx_fetch,
    output logic                           tx_bit,
    output logic                           tx_active,
    output logic [3:0]                     radio_state,
    output logic                           rx_overflow_state,
    output logic                           rx_stuck,
    output logic                           general_output_pin
);
    localparam int CW = $clog2(BIT_CYCLES + 1);

    rrf_pkg::rrf_state_t st_ff;
    rrf_pkg::rrf_state_t nxt_st;
    logic          stuck_ff;
    logic          nxt_stuck;
    logic          in_pkt_ff;
    logic          nxt_in_pkt;
    logic [1:0]    st_pend_ff;
    logic [1:0]    nxt_st_pend;
    logic [7:0]    rssi_hold_ff;
    logic [7:0]    nxt_rssi_hold;
    logic [7:0]    lqi_hold_ff;
    logic [7:0]    nxt_lqi_hold;
    logic          gpo_ff;
    logic          nxt_gpo;
    logic          fifo_full;
    logic          fifo_wr;
    logic [7:0]    fifo_wdata;
    logic          fifo_flush;
    logic          rx_take;
    logic          ovf_evt;
    logic          stuck_case;

    logic [7:0]    shift_ff;
    logic [7:0]    nxt_shift;
    logic [2:0]    bit_idx_ff;
    logic [2:0]    nxt_bit_idx;
    logic [CW-1:0] cyc_ff;
    logic [CW-1:0] nxt_cyc;
    logic          fetch_ff;
    logic          nxt_fetch;
    logic          replay_ff;
    logic          nxt_replay;
    logic          last_ff;
    logic          nxt_last;
    logic          pop_ff;
    logic          nxt_pop;
    logic          bit_end;
    logic          byte_end;

    function automatic logic is_rxish(input rrf_pkg::rrf_state_t s);
        is_rxish = (s == rrf_pkg::RRF_IDLE) || (s == rrf_pkg::RRF_RX_OVF);
    endfunction : is_rxish

    rrf_rx_fifo #(
        .W     (8),
        .DEPTH (`RRF_FIFO_DEPTH),
        .AW    (`RRF_FIFO_AW)
    ) u_fifo (
        .clk      (clk),
        .arst_n   (arst_n),
        .flush    (fifo_flush),
        .wr_en    (fifo_wr),
        .wr_data  (fifo_wdata),
        .full     (fifo_full),
        .rd_en    (rx_rd_en),
        .rd_data  (rx_rd_data),
        .rd_valid (rx_rd_valid),
        .count    (rx_fifo_count)
    );

    // ---- receive side ----
    always_comb begin
        stuck_case = legacy_defect_enable && status_append_enable && !crc_enable;
        rx_take    = (st_ff == rrf_pkg::RRF_RX) && !stuck_ff && !idle_strobe;
        ovf_evt    = rx_take && rx_byte_valid && fifo_full;
        fifo_wr    = 1'b0;
        fifo_wdata = rx_byte;
        nxt_st_pend   = st_pend_ff;
        nxt_rssi_hold = rssi_hold_ff;
        nxt_lqi_hold  = lqi_hold_ff;
        if (rx_take && rx_byte_valid && !fifo_full) begin
            fifo_wr = 1'b1;
        end else if (rx_take && st_pend_ff != 2'h0 && !fifo_full) begin
            // appended status bytes drain from their holding registers
            fifo_wr     = 1'b1;
            fifo_wdata  = st_pend_ff[1] ? rssi_hold_ff : lqi_hold_ff;
            nxt_st_pend = {1'b0, st_pend_ff[1]};
        end
        if (rx_take && rx_pkt_end && status_append_enable) begin
            nxt_st_pend   = 2'h3;
            nxt_rssi_hold = rx_rssi;
            nxt_lqi_hold  = {crc_enable ? rx_crc_ok : rx_lqi[7], rx_lqi[6:0]};
        end
        if (st_ff != rrf_pkg::RRF_RX) begin
            nxt_st_pend = 2'h0;
        end
        // flush honoured only in idle or the overflow state, so from receive idle must come first
        fifo_flush = rx_flush_strobe && is_rxish(st_ff);
    end

    // ---- state machine ----
    always_comb begin
        nxt_st    = st_ff;
        nxt_stuck = stuck_ff;
        bit_end   = (cyc_ff == CW'(BIT_CYCLES - 1));
        byte_end  = bit_end && (bit_idx_ff == `RRF_BITS_PER_BYTE);
        case (st_ff)
            rrf_pkg::RRF_IDLE: begin
                if (rx_strobe) begin
                    nxt_st = rrf_pkg::RRF_RX;
                end else if (tx_strobe && tx_data_avail) begin
                    nxt_st = rrf_pkg::RRF_TX;
                end
            end
            rrf_pkg::RRF_RX: begin
                if (ovf_evt) begin
                    if (stuck_case) begin
                        nxt_stuck = 1'b1;
                    end else begin
                        nxt_st = rrf_pkg::RRF_RX_OVF;
                    end
                end
            end
            rrf_pkg::RRF_RX_OVF: begin
                if (fifo_flush) begin
                    nxt_st = rrf_pkg::RRF_IDLE;
                end
            end
            rrf_pkg::RRF_TX: begin
                if (byte_end && ((last_ff && packet_handling_enable) || !tx_data_avail)) begin
                    nxt_st = rrf_pkg::RRF_IDLE;
                end
            end
            default: begin
                nxt_st = rrf_pkg::RRF_IDLE;
            end
        endcase
        if (idle_strobe) begin
            nxt_st    = rrf_pkg::RRF_IDLE;
            nxt_stuck = 1'b0;
        end
        nxt_in_pkt = in_pkt_ff;
        if (rx_take && rx_pkt_start) begin
            nxt_in_pkt = 1'b1;
        end
        if ((rx_take && rx_pkt_end) || nxt_st != rrf_pkg::RRF_RX) begin
            nxt_in_pkt = 1'b0;
        end
        case (output_pin_select_cfg)
            `RRF_PIN_CFG_PKT_OVF: nxt_gpo = nxt_in_pkt;
            `RRF_PIN_CFG_NONEMPT: nxt_gpo = (rx_fifo_count != '0);
            default:              nxt_gpo = 1'b0;
        endcase
    end

    // ---- transmit modulator ----
    always_comb begin
        nxt_shift   = shift_ff;
        nxt_bit_idx = bit_idx_ff;
        nxt_cyc     = cyc_ff;
        nxt_fetch   = fetch_ff;
        nxt_replay  = replay_ff;
        nxt_last    = last_ff;
        nxt_pop     = 1'b0;
        if (st_ff == rrf_pkg::RRF_IDLE && nxt_st == rrf_pkg::RRF_TX) begin
            nxt_shift   = tx_data;
            nxt_last    = tx_last;
            nxt_pop     = !replay_ff;
            nxt_replay  = 1'b0;
            nxt_fetch   = 1'b1;
            nxt_bit_idx = 3'h0;
            nxt_cyc     = '0;
        end else if (st_ff == rrf_pkg::RRF_TX && nxt_st == rrf_pkg::RRF_TX) begin
            nxt_cyc = bit_end ? '0 : cyc_ff + 1'b1;
            if (bit_end) begin
                nxt_bit_idx = bit_idx_ff + 1'b1;
                nxt_shift   = {shift_ff[6:0], 1'b0};
                if (bit_idx_ff == `RRF_HALF_BYTE - 3'h1) begin
                    nxt_fetch = 1'b0;
                end
            end
            if (byte_end) begin
                nxt_shift = tx_data;
                nxt_last  = tx_last;
                nxt_pop   = 1'b1;
                nxt_fetch = 1'b1;
            end
        end else if (st_ff == rrf_pkg::RRF_TX) begin
            if (idle_strobe && fetch_ff && legacy_defect_enable) begin
                nxt_replay = 1'b1;
            end else begin
                nxt_fetch = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff        <= rrf_pkg::RRF_IDLE;
            stuck_ff     <= 1'b0;
            in_pkt_ff    <= 1'b0;
            st_pend_ff   <= 2'h0;
            rssi_hold_ff <= 8'h00;
            lqi_hold_ff  <= 8'h00;
            gpo_ff       <= 1'b0;
            shift_ff     <= 8'h00;
            bit_idx_ff   <= 3'h0;
            cyc_ff       <= '0;
            fetch_ff     <= 1'b0;
            replay_ff    <= 1'b0;
            last_ff      <= 1'b0;
            pop_ff       <= 1'b0;
        end else begin
            st_ff        <= nxt_st;
            stuck_ff     <= nxt_stuck;
            in_pkt_ff    <= nxt_in_pkt;
            st_pend_ff   <= nxt_st_pend;
            rssi_hold_ff <= nxt_rssi_hold;
            lqi_hold_ff  <= nxt_lqi_hold;
            gpo_ff       <= nxt_gpo;
            shift_ff     <= nxt_shift;
            bit_idx_ff   <= nxt_bit_idx;
            cyc_ff       <= nxt_cyc;
            fetch_ff     <= nxt_fetch;
            replay_ff    <= nxt_replay;
            last_ff      <= nxt_last;
            pop_ff       <= nxt_pop;
        end
    end

    assign tx_pop             = pop_ff;
    assign tx_fetch           = fetch_ff;
    assign tx_bit             = shift_ff[7] & (st_ff == rrf_pkg::RRF_TX);
    assign tx_active          = (st_ff == rrf_pkg::RRF_TX);
    assign radio_state        = st_ff;
    assign rx_overflow_state  = (st_ff == rrf_pkg::RRF_RX_OVF);
    assign rx_stuck           = stuck_ff;
    assign general_output_pin = gpo_ff;

endmodule : rrf_radio_core

// ### logic/rrf_defs.svh
// constants for the radio receive fifo / transmit fetch block
// included by the package users; holds definitions only
`ifndef RRF_DEFS_SVH
`define RRF_DEFS_SVH

`define RRF_FIFO_DEPTH      64
`define RRF_FIFO_AW         6
`define RRF_PIN_CFG_W       6
`define RRF_PIN_CFG_PKT_OVF 6'h06
`define RRF_PIN_CFG_NONEMPT 6'h01
`define RRF_BITS_PER_BYTE   3'h7
`define RRF_HALF_BYTE       3'h4
`define RRF_BIT_CYCLES      8
`define RRF_LEN_VAR_MAX     8'h3d
`define RRF_LEN_FIX_MAX     8'h3e

`endif

// ### logic/rrf_pkg.sv
// types shared by the radio core block
// no dependencies
package rrf_pkg;

    typedef enum logic [3:0] {
        RRF_IDLE   = 4'h1,
        RRF_RX     = 4'h2,
        RRF_RX_OVF = 4'h4,
        RRF_TX     = 4'h8
    } rrf_state_t;

endpackage : rrf_pkg

// ### logic/rrf_rx_fifo.sv
// receive fifo with a one-byte prefetch stage in front of it
// write side is the radio core, read side the processor, same clock
`timescale 1ns/10ps
`include "rrf_defs.svh"

module rrf_rx_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = `RRF_FIFO_DEPTH,
    parameter int AW    = `RRF_FIFO_AW
) (
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire logic          flush,
    input  wire logic          wr_en,
    input  wire logic [W-1:0]  wr_data,
    output logic               full,
    input  wire logic          rd_en,
    output logic [W-1:0]       rd_data,
    output logic               rd_valid,
    output logic [AW:0]        count
);
    logic [W-1:0]  mem [DEPTH];
    logic          pf_valid_ff;
    logic          nxt_pf_valid;
    logic [W-1:0]  pf_data_ff;
    logic [W-1:0]  nxt_pf_data;
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] nxt_wr_ptr;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW-1:0] nxt_rd_ptr;
    logic [AW:0]   cnt_ff;
    logic [AW:0]   nxt_cnt;
    logic [W-1:0]  rd_data_ff;
    logic [W-1:0]  nxt_rd_data;
    logic          rd_valid_ff;
    logic          nxt_rd_valid;
    logic          move;
    logic          pop;

    // full only when both the memory and the prefetch byte are occupied
    assign full     = pf_valid_ff && (cnt_ff == (AW+1)'(DEPTH));
    assign rd_data  = rd_data_ff;
    assign rd_valid = rd_valid_ff;
    assign count    = cnt_ff + (AW+1)'(pf_valid_ff);

    always_comb begin
        pop          = rd_en && (cnt_ff != '0);
        move         = pf_valid_ff && ((cnt_ff != (AW+1)'(DEPTH)) || pop);
        nxt_pf_valid = pf_valid_ff;
        nxt_pf_data  = pf_data_ff;
        nxt_wr_ptr   = wr_ptr_ff;
        nxt_rd_ptr   = rd_ptr_ff;
        nxt_cnt      = cnt_ff;
        nxt_rd_data  = rd_data_ff;
        nxt_rd_valid = 1'b0;
        if (move) begin
            nxt_pf_valid = 1'b0;
            nxt_wr_ptr   = wr_ptr_ff + 1'b1;
        end
        if (wr_en && (!pf_valid_ff || move)) begin
            nxt_pf_valid = 1'b1;
            nxt_pf_data  = wr_data;
        end
        if (pop) begin
            nxt_rd_ptr   = rd_ptr_ff + 1'b1;
            nxt_rd_data  = mem[rd_ptr_ff];
            nxt_rd_valid = 1'b1;
        end
        nxt_cnt = cnt_ff + (AW+1)'(move) - (AW+1)'(pop);
        if (flush) begin
            nxt_pf_valid = 1'b0;
            nxt_wr_ptr   = '0;
            nxt_rd_ptr   = '0;
            nxt_cnt      = '0;
            nxt_rd_valid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pf_valid_ff <= 1'b0;
            pf_data_ff  <= '0;
            wr_ptr_ff   <= '0;
            rd_ptr_ff   <= '0;
            cnt_ff      <= '0;
            rd_data_ff  <= '0;
            rd_valid_ff <= 1'b0;
        end else begin
            pf_valid_ff <= nxt_pf_valid;
            pf_data_ff  <= nxt_pf_data;
            wr_ptr_ff   <= nxt_wr_ptr;
            rd_ptr_ff   <= nxt_rd_ptr;
            cnt_ff      <= nxt_cnt;
            rd_data_ff  <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    always_ff @(posedge clk) begin
        if (move && !flush) begin
            mem[wr_ptr_ff] <= pf_data_ff;
        end
    end

endmodule : rrf_rx_fifo

// ### tb/rrf_radio_core_checker.sv
// concurrent checks on the radio core ports
// bound from the bench; one clock, reset async active low
`timescale 1ns/10ps

module rrf_radio_core_checker #(
    parameter int BIT_CYCLES = 8
) (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       idle_strobe,
    input wire logic       rx_flush_strobe,
    input wire logic [5:0] output_pin_select_cfg,
    input wire logic       legacy_defect_enable,
    input wire logic       rx_byte_valid,
    input wire logic       rx_rd_en,
    input wire logic [6:0] rx_fifo_count,
    input wire logic       tx_fetch,
    input wire logic       tx_active,
    input wire logic [3:0] radio_state,
    input wire logic       rx_overflow_state,
    input wire logic       rx_stuck,
    input wire logic       general_output_pin
);
    localparam int HALF = 4 * BIT_CYCLES;
    logic [7:0] fcnt_ff;
    logic [7:0] nxt_fcnt;

    // cycles the fetch signal has stood high since it last rose while transmitting
    always_comb begin
        nxt_fcnt = (tx_fetch && tx_active) ? fcnt_ff + 8'h01 : 8'h00;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fcnt_ff <= 8'h00;
        end else begin
            fcnt_ff <= nxt_fcnt;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_count_limit: assert property (rx_fifo_count <= 7'h41)
        else $error("fifo count above 65");
    a_ovf_entry: assert property (
        radio_state == 4'h2 && rx_byte_valid && !idle_strobe && !rx_rd_en && !legacy_defect_enable
        && rx_fifo_count == 7'h41 |=> rx_overflow_state) else $error("no overflow on extra byte");
    a_pin_drop: assert property (
        rx_overflow_state && output_pin_select_cfg == 6'h06 && $stable(output_pin_select_cfg)
        |-> !general_output_pin) else $error("pin high in overflow");
    a_idle_wins: assert property (idle_strobe |=> radio_state == 4'h1)
        else $error("idle strobe not obeyed");
    a_flush_empty: assert property (
        rx_flush_strobe && !idle_strobe && (radio_state == 4'h1 || radio_state == 4'h4)
        |=> rx_fifo_count == 7'h00) else $error("flush left data");
    a_stuck_deaf: assert property (
        rx_stuck && !idle_strobe |=> radio_state == 4'h2 && rx_stuck
        && rx_fifo_count <= $past(rx_fifo_count)) else $error("stuck receive changed");
    a_fetch_start: assert property ($rose(tx_active) |-> tx_fetch)
        else $error("fetch low at byte start");
    a_fetch_half: assert property (
        ($fell(tx_fetch) && tx_active |-> fcnt_ff >= HALF - 1) and (fcnt_ff <= HALF + 1))
        else $error("fetch not half a byte");
    a_abort_clear: assert property (idle_strobe && !legacy_defect_enable |=> !tx_fetch)
        else $error("fetch kept after abort");
    a_abort_hold: assert property (
        idle_strobe && legacy_defect_enable && tx_active && tx_fetch && fcnt_ff < HALF - 1
        |=> tx_fetch) else $error("legacy abort cleared fetch");
endmodule : rrf_radio_core_checker

// ### tb/rrf_host_model.sv
// processor side model: drains the receive fifo, holds a four-byte transmit queue
// same clock as the radio core; drain and q_load come from the bench
`timescale 1ns/10ps

module rrf_host_model #(
    parameter int QLEN = 4
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       drain,
    input  wire logic       q_load,
    input  wire logic [6:0] rx_fifo_count,
    input  wire logic       tx_pop,
    output logic            rx_rd_en,
    output logic [7:0]      tx_data,
    output logic            tx_data_avail,
    output logic            tx_last
);
    logic [2:0] idx_ff;
    logic [7:0] head;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idx_ff   <= 3'(QLEN);
            rx_rd_en <= 1'b0;
        end else begin
            idx_ff   <= q_load ? 3'h0 : idx_ff + {2'h0, tx_pop && tx_data_avail};
            rx_rd_en <= drain && rx_fifo_count != 7'h00;
        end
    end

    assign head          = 8'ha0 + {5'h00, idx_ff};
    assign tx_data_avail = idx_ff < 3'(QLEN);
    assign tx_last       = idx_ff == 3'(QLEN - 1);
    // empty queue shows a changed value, not the last head
    assign tx_data       = tx_data_avail ? head : ~head;
endmodule : rrf_host_model

// ### tb/test_radio_rx_fifo_overflow_tx_fetch.sv
// bench for the radio core: overflow and recovery, status fit, fetch on transmit abort
// inputs change at the rising edge, checks sit at the falling edge
`timescale 1ns/10ps

module test_radio_rx_fifo_overflow_tx_fetch;
    localparam int BC = 2;
    logic       clk = 1'b0, arst_n = 1'b0, app = 1'b1, crc = 1'b0, leg = 1'b0, bv = 1'b0;
    logic       ps = 1'b0, pe = 1'b0, drain = 1'b0, qld = 1'b0;
    logic [3:0] stb = 4'h0; // flush, tx, rx, idle
    logic [5:0] cfg = 6'h06;
    logic [7:0] bd = 8'h00, txd, rdd;
    logic [6:0] cnt;
    logic [3:0] st;
    logic       rd_en, rvld, txav, txl, pop, fetch, tbit, act, ovf, stuck, pin;
    int         fail_count = 0;
    int         samples_checked = 0;

    always #2.5 clk = ~clk;

    rrf_radio_core #(.BIT_CYCLES(BC)) i_dut (
        .clk(clk), .arst_n(arst_n), .idle_strobe(stb[0]), .rx_strobe(stb[1]), .tx_strobe(stb[2]),
        .rx_flush_strobe(stb[3]), .output_pin_select_cfg(cfg), .status_append_enable(app), .crc_enable(crc),
        .packet_handling_enable(1'b1), .legacy_defect_enable(leg), .rx_byte_valid(bv), .rx_byte(bd),
        .rx_pkt_start(ps), .rx_pkt_end(pe), .rx_rssi(8'h3c), .rx_lqi(8'h15), .rx_crc_ok(1'b1),
        .rx_rd_en(rd_en), .rx_rd_data(rdd), .rx_rd_valid(rvld), .rx_fifo_count(cnt), .tx_data(txd),
        .tx_data_avail(txav), .tx_last(txl), .tx_pop(pop), .tx_fetch(fetch), .tx_bit(tbit), .tx_active(act),
        .radio_state(st), .rx_overflow_state(ovf), .rx_stuck(stuck), .general_output_pin(pin));

    rrf_host_model i_host (.clk(clk), .arst_n(arst_n), .drain(drain), .q_load(qld), .rx_fifo_count(cnt),
        .tx_pop(pop), .rx_rd_en(rd_en), .tx_data(txd), .tx_data_avail(txav), .tx_last(txl));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic strobe(input logic [3:0] m);
        @(posedge clk) stb <= m;
        @(posedge clk) stb <= 4'h0;
        @(negedge clk);
    endtask : strobe

    task automatic send(input int n, input logic [7:0] b0);
        for (int i = 0; i < n; i++) begin
            @(posedge clk) begin
                bv <= 1'b1;
                bd <= b0 + 8'(i);
            end
        end
        @(posedge clk) bv <= 1'b0;
        @(negedge clk);
    endtask : send

    // fill past full; l selects the legacy stuck combination (append on, crc off)
    task automatic t_overflow(input logic l);
        @(posedge clk) leg <= l;
        strobe(4'h2);
        @(posedge clk) ps <= 1'b1;
        @(posedge clk) ps <= 1'b0;
        send(65, 8'h00);
        chk(cnt, 7'h41);
        chk(pin, 1'h1);
        send(3, 8'h80);
        chk(st, l ? 4'h2 : 4'h4);
        chk(stuck, l);
        chk(pin, l);
        // a flush while still stuck in receive must be refused
        if (l) begin
            strobe(4'h8);
        end
        chk(st, l ? 4'h2 : 4'h4);
        chk(cnt, 7'h41);
        strobe(4'h1);
        chk(st, 4'h1);
        chk(cnt, 7'h41);
        strobe(4'h8);
        chk(cnt, 7'h00);
        chk(stuck, 1'h0);
    endtask : t_overflow

    // 62 bytes plus two status bytes fill the fifo exactly, then drain in order; pin shows non-empty
    task automatic t_fit;
        int k;
        k = 0;
        @(posedge clk) begin
            crc <= 1'b1;
            cfg <= 6'h01;
        end
        strobe(4'h2);
        send(62, 8'h10);
        @(posedge clk) pe <= 1'b1;
        @(posedge clk) pe <= 1'b0;
        repeat (4) @(negedge clk);
        chk(cnt, 7'h40);
        chk(ovf, 1'h0);
        chk(pin, 1'h1);
        @(posedge clk) drain <= 1'b1;
        for (int i = 0; i < 300 && k < 64; i++) begin
            @(negedge clk);
            if (rvld === 1'b1) begin
                chk(rdd, k < 62 ? 8'h10 + 8'(k) : (k == 62 ? 8'h3c : 8'h95));
                k++;
            end
        end
        chk(k, 32'h40);
        @(posedge clk) drain <= 1'b0;
        strobe(4'h1);
        chk(pin, 1'h0);
    endtask : t_fit

    // abort in the first half of a byte, then a full packet
    task automatic t_tx(input logic l);
        logic [15:0] got;
        @(posedge clk) begin
            leg <= l;
            qld <= 1'b1;
        end
        @(posedge clk) qld <= 1'b0;
        strobe(4'h4);
        chk(act, 1'h1);
        chk(fetch, 1'h1);
        chk(pop, 1'h1);
        repeat (BC) @(negedge clk);
        strobe(4'h1);
        chk(fetch, l);
        strobe(4'h4);
        chk(pop, !l);
        for (int i = 0; i < 16; i++) begin
            got[15 - i] = tbit;
            repeat (BC) @(negedge clk);
        end
        chk(got, l ? 16'ha1a1 : 16'ha1a2);
        for (int i = 0; i < 400 && act; i++) @(negedge clk);
        chk(act, 1'h0);
        chk(txav, 1'h0);
    endtask : t_tx

    task automatic tally_and_finish;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        chk(st, 4'h1);
        chk(cnt, 7'h00);
        t_overflow(1'b0);
        t_overflow(1'b1);
        t_fit();
        t_tx(1'b0);
        t_tx(1'b1);
        tally_and_finish();
    end
endmodule : test_radio_rx_fifo_overflow_tx_fetch

bind rrf_radio_core rrf_radio_core_checker #(.BIT_CYCLES(BIT_CYCLES)) i_chk (
    .clk, .arst_n, .idle_strobe, .rx_flush_strobe, .output_pin_select_cfg, .legacy_defect_enable, .rx_byte_valid,
    .rx_rd_en, .rx_fifo_count, .tx_fetch, .tx_active, .radio_state, .rx_overflow_state, .rx_stuck,
    .general_output_pin);
